// file: logic/xover_pkg.sv
// Constants and types shared by the automatic pair crossover block
`default_nettype none

package xover_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_STRAP_CFG1  = 5'h09;  // strap_override_config_one
    localparam logic [4:0]  ADDR_PHY_STATUS  = 5'h10;  // phy_status_summary
    localparam logic [4:0]  ADDR_PHY_CTRL    = 5'h19;  // phy_control_config

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CFG1_EXT_BIT     = 5;      // extended_crossover_mode
    localparam int          CTRL_AUTO_BIT    = 15;     // automatic_pair_swap enable
    localparam int          CTRL_FORCE_BIT   = 14;     // forced state: 1 = crossed
    localparam int          STAT_CROSSED_BIT = 14;     // resolved state: 1 = crossed
    localparam int          STAT_LINK_BIT    = 0;      // link up
    localparam int          STAT_LOCKED_BIT  = 1;      // resolution locked

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] CFG1_RST         = 16'h0000;
    localparam logic [15:0] CFG1_WMASK       = 16'h0020;
    localparam logic [15:0] CTRL_RST         = 16'h0000;
    localparam logic [15:0] CTRL_WMASK       = 16'hC000;
    localparam logic [15:0] RDATA_IDLE       = 16'h0000;

    // ------------------------------------------------------------
    // Timing: crossover sample slot, in milliseconds and MHz
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned SLOT_MS          = 62;     // standard sample slot
    localparam int unsigned EXT_SLOT_MS      = 124;    // stretched slot, forced 100
    localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // Random source seed and timer constants
    // ------------------------------------------------------------
    localparam logic [10:0] LFSR_SEED        = 11'h001;
    localparam logic [31:0] TMR_ZERO         = 32'h0000_0000;
    localparam logic [31:0] TMR_ONE          = 32'h0000_0001;

    // Resolution state
    typedef enum logic {
        ST_SEEK,
        ST_LOCKED
    } xo_state_t;

endpackage : xover_pkg

`default_nettype wire

// file: logic/xover_mac_if.sv
// MAC-side duplex signals shared between the core and the duplex unit
`timescale 1ns/1ps
`default_nettype none

interface xover_mac_if;
    logic tx_en;        // MAC transmit active
    logic rx_act;       // Receive activity on the listen pair
    logic full_duplex;  // 10BASE-T full-duplex selected
    logic col;          // Collision toward MAC
    logic crs;          // Carrier sense toward MAC

    modport core   (output tx_en, output rx_act, output full_duplex,
                    input col, input crs);
    modport duplex (input tx_en, input rx_act, input full_duplex,
                    output col, output crs);
endinterface : xover_mac_if

`default_nettype wire

// file: logic/xover_lfsr.sv
// Pseudo-random bit source for randomized crossover resolution
`timescale 1ns/1ps
`default_nettype none

module xover_lfsr
    import xover_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic srst,
    output logic      rnd_bit
);

    typedef struct packed {
        logic [10:0] sr;
    } lfsr_state_t;

    lfsr_state_t s;
    lfsr_state_t n;

    // ------------------------------------------------------------
    // Eleven-bit maximal sequence, free running so both ends decorrelate
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.sr = {s.sr[9:0], s.sr[10] ^ s.sr[8]};
        if (srst) begin
            n.sr = LFSR_SEED;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= n;
    end

    assign rnd_bit = s.sr[10];

endmodule : xover_lfsr

`default_nettype wire

// file: logic/xover_duplex.sv
// 10BASE-T collision and carrier sense for half and full duplex
`timescale 1ns/1ps
`default_nettype none

module xover_duplex
    import xover_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   srst,
    xover_mac_if.duplex mac
);

    typedef struct packed {
        logic col;
        logic crs;
    } dup_state_t;

    dup_state_t s;
    dup_state_t n;

    // ------------------------------------------------------------
    // Collision only in half duplex; full duplex runs both ways freely
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        if (mac.full_duplex) begin
            n.col = 1'b0;
            n.crs = mac.rx_act;
        end else begin
            n.col = mac.tx_en & mac.rx_act;
            n.crs = mac.tx_en | mac.rx_act;
        end
        if (srst) begin
            n.col = 1'b0;
            n.crs = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= n;
    end

    assign mac.col = s.col;
    assign mac.crs = s.crs;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_fd_no_col: assert property (mac.full_duplex |=> !mac.col)
        else $error("collision raised in full duplex");
    a_hd_col_set: assert property
        (!mac.full_duplex && mac.tx_en && mac.rx_act |=> mac.col && mac.crs)
        else $error("half duplex collision not reported");
    a_fd_crs_rx: assert property
        (mac.full_duplex && mac.tx_en && !mac.rx_act |=> !mac.crs)
        else $error("full duplex carrier sense follows transmit");

endmodule : xover_duplex

`default_nettype wire

// file: logic/auto_crossover_control.sv
// Automatic pair crossover control with 10BASE-T duplex behaviour

`timescale 1ns/1ps
`default_nettype none

module auto_crossover_control
    import xover_pkg::*;
#(
    parameter int unsigned SLOT_CYC     = SLOT_MS * CYC_PER_MS,
    parameter int unsigned EXT_SLOT_CYC = EXT_SLOT_MS * CYC_PER_MS
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Straps and mode inputs
    input  wire logic        crossover_strap,
    input  wire logic        autoneg_active,
    input  wire logic        force_100,
    input  wire logic        full_duplex,
    // Line-side detection
    input  wire logic        energy_tx_pair,
    input  wire logic        energy_rx_pair,
    input  wire logic        signal_detect,
    input  wire logic        link_up,
    // Symbol paths
    input  wire logic        tx_en,
    input  wire logic        tx_sym,
    input  wire logic        tx_pair_rx_sym,
    input  wire logic        rx_pair_rx_sym,
    input  wire logic        rx_active,
    output logic             transmit_pair_en,
    output logic             transmit_pair_sym,
    output logic             receive_pair_en,
    output logic             receive_pair_sym,
    output logic             rx_sym,
    // MAC status
    output logic             col,
    output logic             crs,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        // Resolution
        xo_state_t   st;
        logic        crossed;
        logic [31:0] tmr;
        logic        link_seen;
        // Registers
        logic [15:0] cfg1;
        logic [15:0] ctrl;
        logic [15:0] rdata;
        // Pin drivers
        logic        tp_en;
        logic        tp_sym;
        logic        rp_en;
        logic        rp_sym;
        logic        rx_sym;
    } top_state_t;

    top_state_t  s;
    top_state_t  n;

    // Decoded controls
    logic        rnd_bit;
    logic        auto_en;
    logic        ext_slow;
    logic        listen_hit;
    logic [31:0] slot_last;

    // Duplex signals as one bundle
    xover_mac_if mac ();

    // ------------------------------------------------------------
    // Random source and duplex unit
    // ------------------------------------------------------------
    xover_lfsr u_lfsr (
        .core_clk (core_clk),
        .srst     (srst),
        .rnd_bit  (rnd_bit)
    );

    xover_duplex u_duplex (
        .core_clk (core_clk),
        .srst     (srst),
        .mac      (mac)
    );

    // Duplex unit sees transmit and receive activity side by side
    assign mac.tx_en       = tx_en;
    assign mac.rx_act      = rx_active;
    assign mac.full_duplex = full_duplex;

    // ------------------------------------------------------------
    // Decode of mode and detection
    // ------------------------------------------------------------
    // Software may override the strap in either direction at run time
    assign auto_en  = s.ctrl[CTRL_AUTO_BIT];

    // Only the forced 100 case gets the long slot, so a negotiating
    // crossover partner has time to settle on the opposite state
    assign ext_slow = s.cfg1[CFG1_EXT_BIT] & force_100 & !autoneg_active;

    // Last count of the slot
    assign slot_last = ext_slow ? EXT_SLOT_CYC - 1 : SLOT_CYC - 1;

    // Listen on whichever pair is the receiver in the current state;
    // signal detect covers a legacy 100 partner sending no pulses
    assign listen_hit = (s.crossed ? energy_tx_pair : energy_rx_pair)
                      | (force_100 & signal_detect);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.rdata = RDATA_IDLE;

        // Pair resolution
        if (!auto_en) begin
            // Fixed assignment; the far end must be forced to match
            n.st        = ST_SEEK;
            n.crossed   = s.ctrl[CTRL_FORCE_BIT];
            n.tmr       = TMR_ZERO;
            n.link_seen = 1'b0;
        end else begin
            case (s.st)
                ST_SEEK: begin
                    if (listen_hit) begin
                        n.st  = ST_LOCKED;
                        n.tmr = TMR_ZERO;
                    end else if (s.tmr >= slot_last) begin
                        // Random toggle breaks the tie with a partner
                        // that uses the same scheme
                        n.tmr = TMR_ZERO;
                        if (rnd_bit) begin
                            n.crossed = ~s.crossed;
                        end
                    end else begin
                        n.tmr = s.tmr + TMR_ONE;
                    end
                end

                // Link up freezes the pair
                ST_LOCKED: begin
                    if (link_up) begin
                        n.link_seen = 1'b1;
                        n.tmr       = TMR_ZERO;
                    end else if (s.link_seen) begin
                        n.st        = ST_SEEK;
                        n.link_seen = 1'b0;
                        n.tmr       = TMR_ZERO;
                    end else if (s.tmr >= slot_last) begin
                        // Energy seen but no link formed: try again
                        n.st  = ST_SEEK;
                        n.tmr = TMR_ZERO;
                    end else begin
                        n.tmr = s.tmr + TMR_ONE;
                    end
                end

                // Stray code reseeks
                default: begin
                    n.st = ST_SEEK;
                end
            endcase
        end

        // Pair routing, same for 10 and 100 Mb/s
        // Idle pair stays quiet, no echo
        if (s.crossed) begin
            n.tp_en  = 1'b0;
            n.tp_sym = 1'b0;
            n.rp_en  = tx_en;
            n.rp_sym = tx_sym;
            n.rx_sym = tx_pair_rx_sym;
        end else begin
            n.tp_en  = tx_en;
            n.tp_sym = tx_sym;
            n.rp_en  = 1'b0;
            n.rp_sym = 1'b0;
            n.rx_sym = rx_pair_rx_sym;
        end

        // Register writes
        // Only mask bits take the write
        if (reg_wr) begin
            if (reg_addr == ADDR_STRAP_CFG1) begin
                n.cfg1 = (s.cfg1 & ~CFG1_WMASK) | (reg_wdata & CFG1_WMASK);
            end else if (reg_addr == ADDR_PHY_CTRL) begin
                n.ctrl = (s.ctrl & ~CTRL_WMASK) | (reg_wdata & CTRL_WMASK);
            end
        end

        // Register reads, answered one cycle later
        if (reg_rd) begin
            if (reg_addr == ADDR_STRAP_CFG1) begin
                n.rdata = s.cfg1;
            end else if (reg_addr == ADDR_PHY_CTRL) begin
                n.rdata = s.ctrl;
            end else if (reg_addr == ADDR_PHY_STATUS) begin
                // Live state, no latching
                n.rdata[STAT_CROSSED_BIT] = s.crossed;
                n.rdata[STAT_LINK_BIT]    = link_up;
                n.rdata[STAT_LOCKED_BIT]  = (s.st == ST_LOCKED);
            end else begin
                n.rdata = RDATA_IDLE;
            end
        end

        // Synchronous reset; strap lands in the auto enable bit
        if (srst) begin
            n.st        = ST_SEEK;
            n.crossed   = 1'b0;
            n.tmr       = TMR_ZERO;
            n.link_seen = 1'b0;
            n.cfg1      = CFG1_RST;
            n.ctrl      = CTRL_RST;
            n.ctrl[CTRL_AUTO_BIT] = crossover_strap;
            n.rdata     = RDATA_IDLE;

            // Pins stay quiet in reset
            n.tp_en     = 1'b0;
            n.tp_sym    = 1'b0;
            n.rp_en     = 1'b0;
            n.rp_sym    = 1'b0;
            n.rx_sym    = 1'b0;
        end
    end

    // One register stage for all state
    always_ff @(posedge core_clk) begin
        s <= n;
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign transmit_pair_en  = s.tp_en;
    assign transmit_pair_sym = s.tp_sym;
    assign receive_pair_en   = s.rp_en;
    assign receive_pair_sym  = s.rp_sym;
    assign rx_sym            = s.rx_sym;
    assign reg_rdata         = s.rdata;
    // Duplex flags from its own flops
    assign col               = mac.col;
    assign crs               = mac.crs;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_strap_latch: assert property
        ($fell(srst) |-> s.ctrl[CTRL_AUTO_BIT] == $past(crossover_strap))
        else $error("strap not captured at reset release");

    a_fixed_follows: assert property
        (!auto_en && !reg_wr |=> s.crossed == $past(s.ctrl[CTRL_FORCE_BIT])
            ##1 s.st == ST_SEEK || auto_en)
        else $error("fixed assignment ignores forced state");

    a_pair_route: assert property
        (s.crossed && tx_en |=> receive_pair_en && !transmit_pair_en)
        else $error("crossed state did not swap transmit pair");

    a_route_straight: assert property
        (!s.crossed && tx_en |=> transmit_pair_en && !receive_pair_en)
        else $error("straight state did not use transmit pair");

    a_lock_on_hit: assert property
        (auto_en && s.st == ST_SEEK && listen_hit && !reg_wr |=> s.st == ST_LOCKED)
        else $error("detection did not lock resolution");

    a_sd_lock: assert property
        (auto_en && s.st == ST_SEEK && force_100 && signal_detect && !reg_wr
            |=> s.st == ST_LOCKED)
        else $error("signal detect did not lock resolution");

    a_hold_linked: assert property
        (auto_en && s.st == ST_LOCKED && link_up && !reg_wr
            |=> s.st == ST_LOCKED && $stable(s.crossed))
        else $error("resolved state moved while linked");

    a_drop_reseek: assert property
        (auto_en && s.st == ST_LOCKED && !link_up && s.link_seen && !reg_wr
            |=> s.st == ST_SEEK)
        else $error("link loss did not restart resolution");

    a_slot_wrap: assert property
        (auto_en && s.st == ST_SEEK && !listen_hit && !ext_slow && !reg_wr
            && s.tmr == SLOT_CYC - 1 |=> s.tmr == TMR_ZERO)
        else $error("standard slot length wrong");

    a_ext_slot: assert property
        (auto_en && s.st == ST_SEEK && !listen_hit && ext_slow && !reg_wr
            && s.tmr == SLOT_CYC - 1 |=> s.tmr == SLOT_CYC)
        else $error("extended slot not stretched");

    a_status_bit: assert property
        (reg_rd && reg_addr == ADDR_PHY_STATUS
            |=> reg_rdata[STAT_CROSSED_BIT] == $past(s.crossed))
        else $error("status bit does not show resolved state");

    a_rdata_idle: assert property
        (!reg_rd |=> reg_rdata == RDATA_IDLE)
        else $error("read data stood outside its cycle");

    // Main scenarios of a run
    c_lock: cover property (s.st == ST_SEEK ##1 s.st == ST_LOCKED);
    c_reseek: cover property (s.link_seen ##1 s.st == ST_SEEK);
    c_toggle: cover property (auto_en && $changed(s.crossed));
    c_collide: cover property (col);
    c_ext_wrap: cover property (ext_slow && s.tmr == EXT_SLOT_CYC - 1);

endmodule : auto_crossover_control

`default_nettype wire

// file: tb/link_partner_model.sv
// Behavioural remote link partner held at a fixed straight pair assignment
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic cable_crossed,    // Cable swaps the two pairs
    input  wire logic pulses_on,        // Partner sends link pulses
    input  wire logic sd_on,            // Partner sends a 100 idle stream
    input  wire logic slow,             // Slow link qualification
    input  wire logic transmit_pair_en,
    input  wire logic receive_pair_en,
    output logic      energy_tx_pair,
    output logic      energy_rx_pair,
    output logic      signal_detect,
    output logic      link_up
);
    logic [3:0] hear_cnt;
    logic       hears;

    // ------------------------------------------------------------
    // Line side
    // ------------------------------------------------------------
    // Partner never swaps, so only the cable decides where its pulses land
    assign energy_rx_pair = pulses_on & ~cable_crossed;
    assign energy_tx_pair = pulses_on & cable_crossed;
    assign signal_detect  = sd_on;
    assign hears          = cable_crossed ? receive_pair_en : transmit_pair_en;

    // Link needs our drive on its listen pair for a while; drops at once otherwise
    always_ff @(posedge core_clk) begin
        if (srst || !pulses_on || !hears) begin
            hear_cnt <= 4'h0;
            link_up  <= 1'b0;
        end else if (hear_cnt == (slow ? 4'hC : 4'h2)) begin
            link_up <= 1'b1;
        end else begin
            hear_cnt <= hear_cnt + 4'h1;
        end
    end
endmodule // link_partner_model

`default_nettype wire

// file: tb/auto_crossover_control_tb.sv
// Self-checking bench for the automatic pair crossover block
`timescale 1ns/1ps
`default_nettype none

module auto_crossover_control_tb;
    import xover_pkg::*;

    localparam int unsigned SLOT  = 20;
    localparam int unsigned EXT   = 40;
    localparam int          LIMIT = 20000;   // Whole sequence needs well under this

    logic        core_clk = 1'b0, srst = 1'b1, crossover_strap = 1'b1;
    logic        autoneg_active = 1'b0, force_100 = 1'b0, full_duplex = 1'b0;
    logic        tx_en = 1'b0, tx_sym = 1'b0, tx_pair_rx_sym = 1'b0, rx_pair_rx_sym = 1'b0;
    logic        rx_active = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        cable_crossed = 1'b0, pulses_on = 1'b0, sd_on = 1'b0, slow = 1'b0;
    logic        energy_tx_pair, energy_rx_pair, signal_detect, link_up;
    logic        transmit_pair_en, transmit_pair_sym, receive_pair_en, receive_pair_sym;
    logic        rx_sym, col, crs;
    logic        pchk = 1'b0, pchk_seen = 1'b0, rd_seen = 1'b0;
    logic [31:0] rq[$];
    logic [6:0]  pq[$];
    logic [31:0] ex;
    logic [6:0]  pe, pa;
    logic [31:0] seed = 32'h0001_2710;
    int          n_fail = 0, checks = 0, cyc = 0;

    auto_crossover_control #(.SLOT_CYC(SLOT), .EXT_SLOT_CYC(EXT)) auto_crossover_control_i (
        .core_clk, .srst, .crossover_strap, .autoneg_active, .force_100, .full_duplex,
        .energy_tx_pair, .energy_rx_pair, .signal_detect, .link_up, .tx_en, .tx_sym,
        .tx_pair_rx_sym, .rx_pair_rx_sym, .rx_active, .transmit_pair_en, .transmit_pair_sym,
        .receive_pair_en, .receive_pair_sym, .rx_sym, .col, .crs, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);

    link_partner_model link_partner_model_i (
        .core_clk, .srst, .cable_crossed, .pulses_on, .sd_on, .slow, .transmit_pair_en,
        .receive_pair_en, .energy_tx_pair, .energy_rx_pair, .signal_detect, .link_up);

    // Clock and hang guard
    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            $display("unexpected at %0t: run did not finish in time", $time);
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic miss(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Step lowers all strobes, wr and rd lower only the other one, so no signal is assigned twice in one time step
    task automatic step(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        pchk   <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rq.push_back({e & m, m});
        @(posedge core_clk);
    endtask

    task automatic do_reset(input logic strap);
        srst            <= 1'b1;
        crossover_strap <= strap;
        step(2);
        srst            <= 1'b0;
        crossover_strap <= ~strap;   // Only the copy taken in reset may count
    endtask

    // ------------------------------------------------------------
    // Output watcher: settled values are taken at the falling edge
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        if (rd_seen) begin
            ex = rq.pop_front();
            checks++;
            if ((reg_rdata & ex[15:0]) !== ex[31:16]) miss("register read data");
        end else if (reg_rdata !== RDATA_IDLE) begin
            miss("read data outside its cycle");
        end
        if (pchk_seen) begin
            pe = pq.pop_front();
            pa = {transmit_pair_en, transmit_pair_sym & transmit_pair_en, receive_pair_en,
                  receive_pair_sym & receive_pair_en, rx_sym, col, crs};
            checks++;
            if (pa !== pe) miss("pair or duplex output");
        end
        rd_seen   = reg_rd;
        pchk_seen = pchk;
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Forced state with random traffic; duplex outputs follow the same edge
    task automatic path_run(input logic x);
        logic te, ts, ta, tb, ra, fd;
        wr(ADDR_PHY_CTRL, {1'b0, x, 14'h0000});
        step(2);
        rd(ADDR_PHY_STATUS, {1'b0, x, 14'h0000}, 16'h4000);
        step(1);
        for (int i = 0; i < 64; i++) begin
            seed = xs(seed);
            {te, ts, ta, tb, ra, fd} = seed[5:0];
            tx_en          <= te;
            tx_sym         <= ts;
            tx_pair_rx_sym <= ta;
            rx_pair_rx_sym <= tb;
            rx_active      <= ra;
            full_duplex    <= fd;
            pchk           <= 1'b1;
            pq.push_back({~x & te, ~x & te & ts, x & te, x & te & ts, x ? ta : tb,
                          fd ? 1'b0 : te & ra, fd ? ra : te | ra});
            @(posedge core_clk);
        end
        step(2);
    endtask

    // Automatic resolution against a partner on a straight or crossed cable
    task automatic auto_run(input logic x, input logic sl);
        int n;
        cable_crossed  <= x;
        slow           <= sl;
        autoneg_active <= sl;
        force_100      <= 1'b0;
        pulses_on      <= 1'b1;
        tx_en          <= 1'b1;
        do_reset(1'b1);
        n = 0;
        while (link_up !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        checks++;
        if (link_up !== 1'b1) miss("link never formed");
        rd(ADDR_PHY_STATUS, {1'b0, x, 12'h000, 2'b11}, 16'h4003);
        step(5 * SLOT);
        rd(ADDR_PHY_STATUS, {1'b0, x, 12'h000, 2'b11}, 16'h4003);
        pulses_on <= 1'b0;
        step(4);
        rd(ADDR_PHY_STATUS, 16'h0000, 16'h0003);
        step(1);
    endtask

    // Crossed state may only move at slot ends; extended mode doubles the slot
    task automatic slot_run(input logic ext, input int gap);
        int last, n_tog;
        logic prev;
        pulses_on      <= 1'b0;
        sd_on          <= 1'b0;
        force_100      <= 1'b1;
        autoneg_active <= 1'b0;
        tx_en          <= 1'b1;
        do_reset(1'b1);
        wr(ADDR_STRAP_CFG1, {10'h000, ext, 5'h00});
        step(2);
        prev  = transmit_pair_en;
        last  = -1;
        n_tog = 0;
        for (int i = 0; i < 30 * gap; i++) begin
            @(negedge core_clk);
            if (transmit_pair_en !== prev) begin
                checks++;
                if (last >= 0 && i - last < gap - 1) miss("crossed state moved in a slot");
                last  = i;
                n_tog++;
                prev  = transmit_pair_en;
            end
        end
        checks++;
        if (n_tog == 0) miss("crossed state never moved while seeking");
        @(posedge core_clk);
        step(1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        rd(ADDR_STRAP_CFG1, CFG1_RST, 16'hFFFF);
        rd(ADDR_PHY_CTRL, 16'h8000, 16'hFFFF);
        rd(ADDR_PHY_STATUS, 16'h0000, 16'h0003);
        rd(5'h1F, 16'h0000, 16'hFFFF);
        wr(ADDR_STRAP_CFG1, 16'hFFFF);
        wr(ADDR_PHY_STATUS, 16'hFFFF);
        wr(5'h1F, 16'hFFFF);
        rd(ADDR_STRAP_CFG1, CFG1_WMASK, 16'hFFFF);
        rd(5'h1F, 16'h0000, 16'hFFFF);
        do_reset(1'b0);
        rd(ADDR_PHY_CTRL, 16'h0000, 16'hFFFF);
        wr(ADDR_PHY_CTRL, 16'hFFFF);
        rd(ADDR_PHY_CTRL, CTRL_WMASK, 16'hFFFF);
        path_run(1'b0);
        path_run(1'b1);
        auto_run(1'b0, 1'b0);
        auto_run(1'b1, 1'b0);
        auto_run(1'b1, 1'b1);
        auto_run(1'b0, 1'b1);
        // Signal detect counts only under forced 100
        do_reset(1'b1);
        sd_on <= 1'b1;
        step(3);
        rd(ADDR_PHY_STATUS, 16'h0000, 16'h0002);
        force_100 <= 1'b1;
        step(3);
        rd(ADDR_PHY_STATUS, 16'h0002, 16'h0002);
        step(1);
        slot_run(1'b1, EXT);
        slot_run(1'b0, SLOT);
        step(2);
        conclude();
    end
endmodule // auto_crossover_control_tb

`default_nettype wire
